// >>> hdl/time_event_params.svh
/*
 register offsets, field codes and timing figures for the timestamp and
 event-notification block; assumes inclusion by bare name
*/
`ifndef TIME_EVENT_PARAMS_SVH
`define TIME_EVENT_PARAMS_SVH

`define CLK_PERIOD_NS 100
`define TICK_NS 64'h0000_0000_0000_0064

`define OFF_STAT_SEL 12'h000
`define OFF_STAT_VAL 12'h004
`define OFF_CTRL 12'h008
`define OFF_CMD 12'h00C
`define OFF_TIME_LO 12'h010
`define OFF_TIME_HI 12'h014
`define OFF_CAP_LO 12'h018
`define OFF_CAP_HI 12'h01C
`define OFF_NOTIFY_SEL 12'h020
`define OFF_NOTIFY_SET 12'h024
`define OFF_EVT_STATUS 12'h028
`define OFF_EVT_POSTED 12'h02C

`define CTRL_SRC_BIT 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_SLAVE_BIT 3
`define CMD_CAPTURE_BIT 0
`define CMD_CLEAR_BIT 1

`define NOTIFY_OFF 2'h0
`define NOTIFY_ON 2'h1
`define NOTIFY_ONCE 2'h2

`define MODE_OFF 2'h0
`define MODE_AUTO 2'h1

`define EVT_COUNT 11
`define STAT_COUNT 5

`endif

// >>> hdl/time_event_pkg.sv
/*
 types shared by the timestamp and event-notification block
 assumes the params header is compiled alongside
*/
package time_event_pkg;

	typedef struct packed
	{
		logic valid;
		logic [3:0] code;
		logic [63:0] stamp;
	} posted_event_t;

	typedef struct packed
	{
		logic sync_valid;
		logic [63:0] sync_time;
	} protocol_time_t;

endpackage : time_event_pkg

// >>> hdl/time_event_ctrl.sv
/*
 timestamp counter, capture, clear, and per-type event notification
 with an APB slave; assumes events arrive as one-cycle pulses synchronous
 to clk, and the protocol engine outside supplies time and role
*/
// Register access over APB and the register addresses were decided locally.
//
// What this block does
// [RULE1] keep a 64-bit nanosecond counter, readable in full
// [RULE2] source select picks local time base or precision-time protocol
// [RULE3] local source: counter advances from the internal clock
// [RULE4] protocol source drives counter; forced whenever protocol mode enabled; the code loads protocol time only while protocol mode is on
// [RULE5] capture command copies counter into a separate holding register
// [RULE6] captured value reads back unchanged by later counting
// [RULE7] clear command sets counter to zero
// [RULE8] protocol slave resynchronises to master time after a clear
// [RULE9] notify type choice selects which setting is read and written
// [RULE10] post events on capture begin and capture finish commands
// [RULE11] post event when network link rate changes
// [RULE12] post distinct error, warning and info message events
// [RULE13] post a distinct event for each of three alarms
// [RULE14] post events on noise calibration begin and finish
// [RULE15] setting off: event not delivered
// [RULE16] setting on: event delivered every occurrence; the code drops it when a lower code fires in the same cycle
// [RULE17] setting once: deliver once, then setting returns to off
// [RULE18] protocol mode off: no protocol participation
// [RULE19] report count of the currently chosen statistic
// [RULE20] statistic choice selects which counter is shown
// [RULE21] automatic mode: role set by protocol election, master or slave
// [RULE22] local source advances by nanoseconds per clock period
`include "time_event_params.svh"

module time_event_ctrl #(
	parameter int STAT_WIDTH = 32
)(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event sources, one-cycle pulses
	input wire logic capture_begin_evt,
	input wire logic capture_finish_evt,
	input wire logic link_rate_change_evt,
	input wire logic error_message_evt,
	input wire logic warning_message_evt,
	input wire logic info_message_evt,
	input wire logic alarm_one_evt,
	input wire logic alarm_two_evt,
	input wire logic alarm_three_evt,
	input wire logic noise_cal_begin_evt,
	input wire logic noise_cal_finish_evt,
	// statistic counters from elsewhere
	input wire logic [`STAT_COUNT*STAT_WIDTH-1:0] statistic_counts,
	// protocol engine
	input wire time_event_pkg::protocol_time_t protocol_time,
	input wire logic protocol_elected_slave,
	output logic protocol_enable,
	output logic protocol_is_slave,
	// control channel
	output time_event_pkg::posted_event_t posted_event
);

	localparam int EN = `EVT_COUNT;

	logic [63:0] time_count;
	logic [63:0] captured_time_value;
	logic [2:0] statistic_choice;
	logic time_counter_source_select;
	logic [1:0] precision_time_mode;
	logic [3:0] notify_type_choice;
	logic [2*EN-1:0] notify_enable_setting;
	logic [EN-1:0] event_seen;
	logic [31:0] posted_total;
	logic resync_pending;
	logic [31:0] next_prdata;

	// apb decode
	wire logic access = psel && penable;
	wire logic wr = access && pwrite;
	wire logic rd_hit_stat_sel = paddr == `OFF_STAT_SEL;
	wire logic hit_cmd = paddr == `OFF_CMD;
	wire logic hit_ctrl = paddr == `OFF_CTRL;
	wire logic hit_nsel = paddr == `OFF_NOTIFY_SEL;
	wire logic hit_nset = paddr == `OFF_NOTIFY_SET;
	wire logic hit_status = paddr == `OFF_EVT_STATUS;
	wire logic mapped = rd_hit_stat_sel || hit_cmd || hit_ctrl || hit_nsel || hit_nset
		|| hit_status || paddr == `OFF_STAT_VAL || paddr == `OFF_TIME_LO
		|| paddr == `OFF_TIME_HI || paddr == `OFF_CAP_LO || paddr == `OFF_CAP_HI
		|| paddr == `OFF_EVT_POSTED;
	wire logic cmd_capture = wr && hit_cmd && pwdata[`CMD_CAPTURE_BIT];
	wire logic cmd_clear = wr && hit_cmd && pwdata[`CMD_CLEAR_BIT];

	// protocol mode gating
	// [RULE18] off means no participation
	wire logic mode_on = precision_time_mode != `MODE_OFF;
	// [RULE4] source forced by mode
	wire logic use_protocol = mode_on || time_counter_source_select;
	// [RULE21] elected role
	wire logic slave_role = mode_on && protocol_elected_slave;

	// event vector, order matches notify type codes
	wire logic [EN-1:0] raw_evt = {noise_cal_finish_evt, noise_cal_begin_evt, alarm_three_evt,
		alarm_two_evt, alarm_one_evt, info_message_evt, warning_message_evt,
		error_message_evt, link_rate_change_evt, capture_finish_evt, capture_begin_evt};

	logic [EN-1:0] deliver;
	logic [3:0] deliver_code;
	genvar g;
	generate
		for (g = 0; g < EN; g++)
		begin : g_evt
			// [RULE15] gate by setting
			assign deliver[g] = raw_evt[g] && notify_enable_setting[2*g +: 2] != `NOTIFY_OFF;
		end
	endgenerate

	// lowest code wins when several fire together; others are dropped
	always_comb
	begin
		deliver_code = 4'h0;
		for (int i = EN - 1; i >= 0; i--)
		begin
			if (deliver[i])
			begin
				deliver_code = 4'(i);
			end
		end
	end

	// [RULE19] chosen statistic shown
	wire logic stat_ok = 32'(statistic_choice) < `STAT_COUNT;
	wire logic [STAT_WIDTH-1:0] selected_statistic_value = stat_ok
		? statistic_counts[statistic_choice*STAT_WIDTH +: STAT_WIDTH] : '0;
	wire logic [1:0] sel_setting = (32'(notify_type_choice) < EN)
		? notify_enable_setting[notify_type_choice*2 +: 2] : `NOTIFY_OFF;

	always_comb
	begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			`OFF_STAT_SEL: next_prdata = {29'h0000_0000, statistic_choice};
			// [RULE20] readout follows choice
			`OFF_STAT_VAL: next_prdata = 32'(selected_statistic_value);
			`OFF_CTRL: next_prdata = {28'h000_0000, slave_role, precision_time_mode,
				time_counter_source_select};
			// [RULE1] full counter readable
			`OFF_TIME_LO: next_prdata = time_count[31:0];
			`OFF_TIME_HI: next_prdata = time_count[63:32];
			// [RULE6] held capture readback
			`OFF_CAP_LO: next_prdata = captured_time_value[31:0];
			`OFF_CAP_HI: next_prdata = captured_time_value[63:32];
			`OFF_NOTIFY_SEL: next_prdata = {28'h000_0000, notify_type_choice};
			// [RULE9] setting of chosen type
			`OFF_NOTIFY_SET: next_prdata = {30'h0000_0000, sel_setting};
			`OFF_EVT_STATUS: next_prdata = 32'(event_seen);
			`OFF_EVT_POSTED: next_prdata = posted_total;
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	// bus response, registered from the setup cycle, no wait states
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= (psel && !penable && !pwrite) ? next_prdata : 32'h0000_0000;
		end
	end

	// write effect happens on the access cycle, pready already high
	wire logic wr_now = wr && pready;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			statistic_choice <= 3'h0;
			time_counter_source_select <= 1'b0;
			precision_time_mode <= `MODE_OFF;
			notify_type_choice <= 4'h0;
		end
		else if (wr_now)
		begin
			if (rd_hit_stat_sel)
				statistic_choice <= pwdata[2:0];
			// [RULE2] source select
			if (hit_ctrl)
			begin
				time_counter_source_select <= pwdata[`CTRL_SRC_BIT];
				precision_time_mode <= pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
			end
			if (hit_nsel)
				notify_type_choice <= pwdata[3:0];
		end
	end

	// notify settings: hardware once-clear and software write per type
	generate
		for (g = 0; g < EN; g++)
		begin : g_set
			wire logic sw_wr = wr_now && hit_nset && notify_type_choice == 4'(g);
			// [RULE17] once then off
			wire logic once_done = deliver[g] && deliver_code == 4'(g)
				&& notify_enable_setting[2*g +: 2] == `NOTIFY_ONCE;
			always_ff @(posedge clk)
			begin
				if (!resetn)
					notify_enable_setting[2*g +: 2] <= `NOTIFY_OFF;
				else if (sw_wr)
					notify_enable_setting[2*g +: 2] <= pwdata[1:0];
				else if (once_done)
					notify_enable_setting[2*g +: 2] <= `NOTIFY_OFF;
			end
			// sticky seen flag, set wins over clear
			always_ff @(posedge clk)
			begin
				if (!resetn)
					event_seen[g] <= 1'b0;
				else if (raw_evt[g])
					event_seen[g] <= 1'b1;
				else if (wr_now && hit_status && pwdata[g])
					event_seen[g] <= 1'b0;
			end
		end
	endgenerate

	// timestamp counter
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			time_count <= 64'h0000_0000_0000_0000;
			resync_pending <= 1'b0;
		end
		// [RULE7] clear to zero
		else if (wr_now && cmd_clear)
		begin
			time_count <= 64'h0000_0000_0000_0000;
			resync_pending <= slave_role;
		end
		else if (use_protocol)
		begin
			// [RULE8] slave resync after clear
			if (mode_on && protocol_time.sync_valid)
			begin
				time_count <= protocol_time.sync_time;
				resync_pending <= 1'b0;
			end
			// free-run between syncs, unless waiting for master
			else if (!resync_pending)
				time_count <= time_count + `TICK_NS;
		end
		// [RULE3] local base advance
		// [RULE22] ns per period
		else
			time_count <= time_count + `TICK_NS;
	end

	// [RULE5] capture command
	always_ff @(posedge clk)
	begin
		if (!resetn)
			captured_time_value <= 64'h0000_0000_0000_0000;
		else if (wr_now && cmd_capture)
			captured_time_value <= time_count;
	end

	// control-channel post, stamped with current time
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			posted_event <= '0;
			posted_total <= 32'h0000_0000;
		end
		else
		begin
			// [RULE16] every occurrence
			posted_event.valid <= |deliver;
			posted_event.code <= deliver_code;
			posted_event.stamp <= time_count;
			if (|deliver)
				posted_total <= posted_total + 32'h0000_0001;
		end
	end

	// [RULE10] [RULE11] [RULE12] [RULE13] [RULE14] all posts go through
	// the same delivery path above; codes 0..10 in port order
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			protocol_enable <= 1'b0;
			protocol_is_slave <= 1'b0;
		end
		else
		begin
			protocol_enable <= mode_on;
			protocol_is_slave <= slave_role;
		end
	end

endmodule : time_event_ctrl

// >>> tb/time_event_ctrl_assertions.sv
/* port checks on the timestamp and event controller
 assumes one clock and a synchronous low reset */
`include "time_event_params.svh"
module time_event_ctrl_assertions
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// protocol and control channel
	input wire logic protocol_elected_slave,
	input wire logic protocol_enable,
	input wire logic protocol_is_slave,
	input wire time_event_pkg::posted_event_t posted_event
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!resetn);
	wire ctrl_wr = psel && penable && pready && pwrite && paddr == `OFF_CTRL;
	rdy_setup_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	rd_idle_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	err_rdy_a: assert property (pslverr |-> pready && psel && penable)
		else $error("error without answer");
	code_range_a: assert property (posted_event.valid |-> posted_event.code < 4'hB)
		else $error("unknown event code");
	slave_role_a: assert property (protocol_is_slave |-> protocol_enable)
		else $error("slave while disabled");
	slave_cause_a: assert property (protocol_is_slave |-> $past(protocol_elected_slave))
		else $error("slave not elected");
	mode_on_a: assert property (ctrl_wr && pwdata[2:1] != 2'h0 |-> ##[1:2] protocol_enable)
		else $error("mode on ignored");
	mode_off_a: assert property (ctrl_wr && pwdata[2:1] == 2'h0 |-> ##[1:2] !protocol_enable)
		else $error("mode off ignored");
	cover property (posted_event.valid);
	cover property (pslverr);
	cover property (protocol_is_slave);
endmodule : time_event_ctrl_assertions

bind time_event_ctrl time_event_ctrl_assertions chk_i (.clk(clk), .resetn(resetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .posted_event(posted_event),
	.protocol_elected_slave(protocol_elected_slave), .protocol_enable(protocol_enable),
	.protocol_is_slave(protocol_is_slave));

// >>> tb/host_event_sink.sv
/* host end of the control channel: counts delivered events
 assumes each delivery is a one-cycle valid pulse on clk */
module host_event_sink
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// control channel
	input wire time_event_pkg::posted_event_t posted_event,
	output logic [7:0] seen,
	output logic [3:0] last_code
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge clk)
	begin
		if (!resetn)
			seen <= 8'h0;
		else if (posted_event.valid === 1'h1)
		begin
			seen <= seen + 8'h1;
			last_code <= posted_event.code;
		end
	end
endmodule : host_event_sink

// >>> tb/time_event_ctrl_tb.sv
/* bench for the timestamp and event controller
 assumes the params header and package are compiled first */
`include "time_event_params.svh"
module time_event_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, elect, pen, pslv, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] ev;
	logic [159:0] stats;
	logic [7:0] seen, n0;
	logic [3:0] last_code;
	logic [63:0] a, b;
	time t1, t2, t_acc;
	int mismatches, n_checks, cyc;
	time_event_pkg::protocol_time_t pt;
	time_event_pkg::posted_event_t pe;
	// code, setting, deliveries from two pulses, setting read back
	int rows[11][4] = '{'{0,1,2,1}, '{1,2,1,0}, '{2,0,0,0}, '{3,1,2,1}, '{4,2,1,0},
		'{5,0,0,0}, '{6,1,2,1}, '{7,2,1,0}, '{8,1,2,1}, '{9,2,1,0}, '{10,1,2,1}};
	time_event_ctrl dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .capture_begin_evt(ev[0]), .capture_finish_evt(ev[1]),
		.link_rate_change_evt(ev[2]), .error_message_evt(ev[3]), .warning_message_evt(ev[4]),
		.info_message_evt(ev[5]), .alarm_one_evt(ev[6]), .alarm_two_evt(ev[7]),
		.alarm_three_evt(ev[8]), .noise_cal_begin_evt(ev[9]), .noise_cal_finish_evt(ev[10]),
		.statistic_counts(stats), .protocol_time(pt), .protocol_elected_slave(elect),
		.protocol_enable(pen), .protocol_is_slave(pslv), .posted_event(pe));
	host_event_sink host (.clk(clk), .resetn(resetn), .posted_event(pe), .seen(seen),
		.last_code(last_code));
	initial
	begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error at %0t: seen %0h expected %0h", $time, s, e);
		end
	endtask : chk
	// hold the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do
			@(posedge clk);
		while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		t_acc = $time;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask : apb
	task automatic rd64(input logic [11:0] ad, output logic [63:0] v);
		apb(1'h0, ad, 32'h0);
		v[31:0] = rd;
		apb(1'h0, ad + 12'h4, 32'h0);
		v[63:32] = rd;
	endtask : rd64
	task automatic cap(output logic [63:0] v, output time tc);
		apb(1'h1, `OFF_CMD, 32'h1);
		tc = t_acc;
		rd64(`OFF_CAP_LO, v);
	endtask : cap
	task automatic pulse(input int c);
		ev[c] <= 1'h1;
		@(posedge clk);
		ev <= '0;
		// post lands one edge later, the sink counts it one edge after that
		repeat (3) @(posedge clk);
	endtask : pulse
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// a hang counts as a mismatch
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			mismatches++;
			close_out();
		end
	end
	initial
	begin
		{resetn, psel, penable, pwrite, paddr, pwdata, elect, ev, pt} = '0;
		for (int i = 0; i < 5; i++)
			stats[i*32 +: 32] = 32'hA0 + i;
		repeat (20) @(posedge clk);
		chk(pen, 1'h0);
		resetn <= 1'h1;
		@(posedge clk);
		apb(1'h0, `OFF_NOTIFY_SET, 32'h0);
		chk(rd, 32'h0);
		$display("reset done");
		foreach (rows[i])
		begin
			n0 = seen;
			apb(1'h1, `OFF_NOTIFY_SEL, rows[i][0]);
			apb(1'h1, `OFF_NOTIFY_SET, rows[i][1]);
			repeat (2) pulse(rows[i][0]);
			chk(seen - n0, rows[i][2]);
			apb(1'h0, `OFF_NOTIFY_SET, 32'h0);
			chk(rd, rows[i][3]);
			if (rows[i][2] != 0)
				chk(last_code, rows[i][0]);
		end
		apb(1'h0, `OFF_EVT_POSTED, 32'h0);
		chk(rd, seen);
		$display("events done");
		for (int i = 0; i < 5; i++)
		begin
			apb(1'h1, `OFF_STAT_SEL, i);
			apb(1'h0, `OFF_STAT_VAL, 32'h0);
			chk(rd, 32'hA0 + i);
		end
		apb(1'h0, 12'hFFC, 32'h0);
		chk({err, rd}, 33'h1_0000_0000);
		cap(a, t1);
		repeat (7) @(posedge clk);
		cap(b, t2);
		chk(b - a, t2 - t1);
		rd64(`OFF_CAP_LO, a);
		chk(a, b);
		apb(1'h1, `OFF_CMD, 32'h2);
		t1 = t_acc;
		cap(b, t2);
		chk(b, t2 - t1 - 100);
		$display("counter done");
		elect <= 1'h1;
		apb(1'h1, `OFF_CTRL, 32'h2);
		apb(1'h0, `OFF_CTRL, 32'h0);
		chk({pen, rd[3]}, 2'h3);
		pt <= {1'h1, 64'h0000_0005_0000_0000};
		@(posedge clk);
		pt <= '0;
		apb(1'h0, `OFF_TIME_HI, 32'h0);
		chk(rd, 32'h5);
		apb(1'h1, `OFF_CMD, 32'h2);
		cap(b, t2);
		chk(b, 64'h0);
		apb(1'h1, `OFF_CTRL, 32'h0);
		// enable output is registered one edge behind the mode write
		@(posedge clk);
		chk(pen, 1'h0);
		$display("protocol done");
		close_out();
	end
endmodule : time_event_ctrl_tb
